// file: inc/bus_master_unit_cfg.svh
`ifndef BUS_MASTER_UNIT_CFG_SVH
`define BUS_MASTER_UNIT_CFG_SVH
// ----------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------
`define BUS_MASTER_UNIT_IDX_ADDR 8'hf4
`define BUS_MASTER_UNIT_IDX_CTRL 8'hf5
`define BUS_MASTER_UNIT_IDX_BUF 8'hf6
`define BUS_MASTER_UNIT_IDX_TP 8'hf7
`define BUS_MASTER_UNIT_RST_ADDR 8'h00
`define BUS_MASTER_UNIT_RST_BUF 8'h00
`define BUS_MASTER_UNIT_RST_TP 8'h01
// ----------------------------------------
// control bits on write
// ----------------------------------------
`define BUS_MASTER_UNIT_C_SRST 7
`define BUS_MASTER_UNIT_C_FILT 6
`define BUS_MASTER_UNIT_C_HS 4
`define BUS_MASTER_UNIT_C_ACK 3
`define BUS_MASTER_UNIT_C_STOP 2
`define BUS_MASTER_UNIT_C_START 1
`define BUS_MASTER_UNIT_C_RUN 0
// ----------------------------------------
// status bits on read
// ----------------------------------------
`define BUS_MASTER_UNIT_S_BUS_BUSY_FLAG 6
`define BUS_MASTER_UNIT_S_IDLE 5
`define BUS_MASTER_UNIT_S_ARB 4
`define BUS_MASTER_UNIT_S_DNACK 3
`define BUS_MASTER_UNIT_S_ANACK 2
`define BUS_MASTER_UNIT_S_ERR 1
`define BUS_MASTER_UNIT_S_BUSY 0
// ----------------------------------------
// timing
// ----------------------------------------
`define BUS_MASTER_UNIT_SCL_DIV 8
`define BUS_MASTER_UNIT_QUARTERS 4
`define BUS_MASTER_UNIT_CLK_MHZ 50
`define BUS_MASTER_UNIT_FILT_NS 50
`define BUS_MASTER_UNIT_FILT_CYC ((`BUS_MASTER_UNIT_FILT_NS * `BUS_MASTER_UNIT_CLK_MHZ + 999) / 1000)
`define BUS_MASTER_UNIT_MCODE 8'h08
`define BUS_MASTER_UNIT_ACK_BIT 4'h8
`endif

// file: inc/bus_master_unit_pkg.sv
package bus_master_unit_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BYTE, ST_STOP} bus_master_unit_state_t;
  typedef enum logic [1:0] {MD_IDLE, MD_TX, MD_RX} bus_master_unit_mode_t;
  typedef struct packed {
    logic valid;
    logic start;
    logic xfer;
    logic rx;
    logic ack;
    logic stop;
    logic hs;
  } bus_master_unit_op_t;
  typedef struct packed {
    logic arb;
    logic dnack;
    logic anack;
    logic err;
  } bus_master_unit_flags_t;
endpackage

// file: src/bus_master_unit_master.sv
// Behaviour
// - scl period is eight times (setting plus one) system clock periods
// - address register holds 7-bit target address above, direction in bit 0
// - buffered byte goes out msb first on the next send
// - buffer read returns the byte of the last receive
// - control writes command bits; reads return bus and master status
// - soft reset clears machine and registers, then clears itself
// - optional filter drops pulses under 50 ns on both lines
// - idle status reads one while the master is idle
// - busy status set while transmitting or receiving
// - bus busy set by start, cleared by stop on the bus
// - error set on address nack, data nack or lost arbitration
// - address nack flag set when address gets no acknowledge
// - data nack flag set when sent data gets no acknowledge
// - arbitration lost flag set when arbitration is lost
// - arbitration and clock synchronisation for multi-master buses
// - start bit gives start from idle, repeated start when owning bus
// - stop bit ends with stop unless address or sent data gets a nack, otherwise bus kept for a burst
// - interrupt on completion or abort of a command
// - ack bit acknowledges received bytes, clear gives a nack
// - idle send command gives start, address, data, optional stop
// - idle receive commands; ack together with stop is illegal
// - high-speed command sends master code and enters high-speed mode
// - unlisted command combinations do nothing, except run alone in receiver mode, which receives the next byte
// - run alone in transmitter mode sends the next byte
`include "bus_master_unit_cfg.svh"
`default_nettype none
module bus_master_unit_master #(
  parameter int FILT_CYC = `BUS_MASTER_UNIT_FILT_CYC
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic DONE_IRQ,
  output logic HS_MODE
);
  // ----------------------------------------
  // register decode
  // ----------------------------------------
  function automatic logic [2:0] reg_sel(input logic [9:0] a);
    reg_sel = 3'h0;
    if (a[9:2] == `BUS_MASTER_UNIT_IDX_ADDR) reg_sel = 3'h4;
    if (a[9:2] == `BUS_MASTER_UNIT_IDX_CTRL) reg_sel = 3'h5;
    if (a[9:2] == `BUS_MASTER_UNIT_IDX_BUF) reg_sel = 3'h6;
    if (a[9:2] == `BUS_MASTER_UNIT_IDX_TP) reg_sel = 3'h7;
  endfunction

  logic soft_rst;
  logic rst;
  logic [7:0] addr_dir;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic [7:0] period;
  logic filt_en;
  logic wr;
  logic [2:0] wsel;
  bus_master_unit_pkg::bus_master_unit_state_t state;
  bus_master_unit_pkg::bus_master_unit_mode_t mode;
  bus_master_unit_pkg::bus_master_unit_op_t op;
  bus_master_unit_pkg::bus_master_unit_op_t next_op;
  bus_master_unit_pkg::bus_master_unit_flags_t flags;
  logic bus_busy;
  logic [7:0] status;

  assign rst = SRST | soft_rst;
  assign PREADY = 1'b1;
  assign wr = PSEL & PENABLE & PWRITE;
  assign wsel = reg_sel(PADDR);

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      soft_rst <= 1'b0;
    else
      soft_rst <= wr && wsel == 3'h5 && PWDATA[`BUS_MASTER_UNIT_C_SRST];
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (rst)
    begin
      addr_dir <= `BUS_MASTER_UNIT_RST_ADDR;
      tx_byte <= `BUS_MASTER_UNIT_RST_BUF;
      period <= `BUS_MASTER_UNIT_RST_TP;
      filt_en <= 1'b0;
    end
    else if (wr)
    begin
      if (wsel == 3'h4) addr_dir <= PWDATA[7:0];
      if (wsel == 3'h6) tx_byte <= PWDATA[7:0];
      if (wsel == 3'h7) period <= PWDATA[7:0];
      if (wsel == 3'h5) filt_en <= PWDATA[`BUS_MASTER_UNIT_C_FILT];
    end
  end

  always_comb
  begin
    status = 8'h00;
    status[`BUS_MASTER_UNIT_S_BUS_BUSY_FLAG] = bus_busy;
    status[`BUS_MASTER_UNIT_S_IDLE] = mode == bus_master_unit_pkg::MD_IDLE;
    status[`BUS_MASTER_UNIT_S_ARB] = flags.arb;
    status[`BUS_MASTER_UNIT_S_DNACK] = flags.dnack;
    status[`BUS_MASTER_UNIT_S_ANACK] = flags.anack;
    status[`BUS_MASTER_UNIT_S_ERR] = flags.err;
    status[`BUS_MASTER_UNIT_S_BUSY] = state != bus_master_unit_pkg::ST_IDLE;
  end

  // read data is captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end
    else if (PSEL && !PENABLE)
    begin
      PSLVERR <= wsel == 3'h0;
      case (wsel)
        3'h4: PRDATA <= {24'h0, addr_dir};
        3'h5: PRDATA <= {24'h0, status};
        3'h6: PRDATA <= {24'h0, rx_byte};
        3'h7: PRDATA <= {24'h0, period};
        default: PRDATA <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // line synchronisers and glitch filter
  // ----------------------------------------
  logic [1:0] line_in;
  logic [1:0] line_f;
  logic [1:0] line_q;
  assign line_in = {SDA_IN, SCL_IN};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gl
      logic [2:0] sync;
      logic synced;
      logic [7:0] stable_cnt;
      always_ff @(posedge CLK_SYS)
      begin
        if (rst)
        begin
          sync <= 3'h7;
          synced <= 1'b1;
          stable_cnt <= 8'h00;
          line_f[g] <= 1'b1;
        end
        else
        begin
          sync <= {sync[1:0], line_in[g]};
          if (sync[1] == sync[2])
            synced <= sync[2];
          if (synced == line_f[g])
            stable_cnt <= 8'h00;
          else
            stable_cnt <= stable_cnt + 8'h01;
          // shorter pulses never reach the count and are dropped
          if (synced != line_f[g] && (!filt_en || stable_cnt >= 8'(FILT_CYC - 1)))
            line_f[g] <= synced;
        end
      end
    end
  endgenerate

  wire scl_f = line_f[0];
  wire sda_f = line_f[1];

  always_ff @(posedge CLK_SYS)
  begin
    if (rst)
    begin
      line_q <= 2'h3;
      bus_busy <= 1'b0;
    end
    else
    begin
      line_q <= line_f;
      if (scl_f && line_q[0] && line_q[1] && !sda_f)
        bus_busy <= 1'b1;
      else if (scl_f && line_q[0] && !line_q[1] && sda_f)
        bus_busy <= 1'b0;
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  always_comb
  begin
    logic [7:0] c;
    logic own;
    c = PWDATA[7:0];
    own = mode != bus_master_unit_pkg::MD_IDLE;
    next_op = '0;
    next_op.start = c[`BUS_MASTER_UNIT_C_START];
    next_op.ack = c[`BUS_MASTER_UNIT_C_ACK];
    next_op.stop = c[`BUS_MASTER_UNIT_C_STOP];
    next_op.xfer = c[`BUS_MASTER_UNIT_C_RUN];
    next_op.rx = c[`BUS_MASTER_UNIT_C_START] ? addr_dir[0] : mode == bus_master_unit_pkg::MD_RX;
    if (c[`BUS_MASTER_UNIT_C_HS])
    begin
      // only the plain master code request from idle is accepted
      next_op.valid = !own && c[3:0] == 4'h1 && !addr_dir[0];
      next_op.hs = 1'b1;
      next_op.start = 1'b1;
      next_op.xfer = 1'b0;
      next_op.stop = 1'b0;
    end
    else if (c[`BUS_MASTER_UNIT_C_START])
      next_op.valid = c[`BUS_MASTER_UNIT_C_RUN];
    else if (own)
      next_op.valid = c[`BUS_MASTER_UNIT_C_RUN] | c[`BUS_MASTER_UNIT_C_STOP];
    if (next_op.rx && next_op.xfer && next_op.ack && next_op.stop)
      next_op.valid = 1'b0;
    if (state != bus_master_unit_pkg::ST_IDLE)
      next_op.valid = 1'b0;
  end

  // ----------------------------------------
  // bit engine
  // ----------------------------------------
  logic [9:0] qcnt;
  logic [1:0] qph;
  logic [3:0] bit_idx;
  logic [7:0] shift;
  logic is_addr;
  logic scl_low;
  logic sda_low;
  logic tick;
  logic stall;
  logic [9:0] qlen;

  assign qlen = 10'((`BUS_MASTER_UNIT_SCL_DIV / `BUS_MASTER_UNIT_QUARTERS) * (period + 10'h1));
  // waiting here for scl to rise lets slower masters or slaves stretch the clock
  assign stall = qph == 2'h2 && !scl_low && !scl_f;
  assign tick = qcnt == 10'h0 && !stall;

  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE = scl_low;
  assign SDA_OE = sda_low;

  always_ff @(posedge CLK_SYS)
  begin
    if (rst)
      qcnt <= 10'h0;
    else if (state == bus_master_unit_pkg::ST_IDLE || tick)
      qcnt <= qlen - 10'h1;
    else if (qcnt != 10'h0)
      qcnt <= qcnt - 10'h1;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (rst)
    begin
      state <= bus_master_unit_pkg::ST_IDLE;
      mode <= bus_master_unit_pkg::MD_IDLE;
      op <= '0;
      flags <= '0;
      qph <= 2'h0;
      bit_idx <= 4'h0;
      shift <= 8'h00;
      is_addr <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      rx_byte <= `BUS_MASTER_UNIT_RST_BUF;
      DONE_IRQ <= 1'b0;
      HS_MODE <= 1'b0;
    end
    else
    begin
      DONE_IRQ <= 1'b0;
      case (state)
        bus_master_unit_pkg::ST_IDLE:
        begin
          if (wr && wsel == 3'h5 && next_op.valid && !PWDATA[`BUS_MASTER_UNIT_C_SRST])
          begin
            op <= next_op;
            flags <= '0;
            qph <= 2'h0;
            bit_idx <= 4'h0;
            if (next_op.start)
              state <= bus_master_unit_pkg::ST_START;
            else if (next_op.xfer)
            begin
              state <= bus_master_unit_pkg::ST_BYTE;
              is_addr <= 1'b0;
              shift <= next_op.rx ? 8'hff : tx_byte;
            end
            else
              state <= bus_master_unit_pkg::ST_STOP;
          end
        end
        bus_master_unit_pkg::ST_START:
        begin
          if (tick)
          begin
            qph <= qph + 2'h1;
            case (qph)
              2'h0: sda_low <= 1'b0;
              2'h1: scl_low <= 1'b0;
              2'h2:
              begin
                if (!sda_f)
                begin
                  // someone else holds data low: give the bus up
                  state <= bus_master_unit_pkg::ST_IDLE;
                  mode <= bus_master_unit_pkg::MD_IDLE;
                  flags <= 4'b1001;
                  DONE_IRQ <= 1'b1;
                end
                else
                  sda_low <= 1'b1;
              end
              default:
              begin
                scl_low <= 1'b1;
                state <= bus_master_unit_pkg::ST_BYTE;
                is_addr <= 1'b1;
                bit_idx <= 4'h0;
                shift <= op.hs ? `BUS_MASTER_UNIT_MCODE : addr_dir;
              end
            endcase
          end
        end
        bus_master_unit_pkg::ST_BYTE:
        begin
          if (tick)
          begin
            qph <= qph + 2'h1;
            case (qph)
              2'h0:
              begin
                if (bit_idx == `BUS_MASTER_UNIT_ACK_BIT)
                  sda_low <= (op.rx && !is_addr) ? op.ack : 1'b0;
                else
                  sda_low <= (op.rx && !is_addr) ? 1'b0 : !shift[7];
              end
              2'h1: scl_low <= 1'b0;
              2'h2: ;
              default:
              begin
                scl_low <= 1'b1;
                bit_idx <= bit_idx + 4'h1;
                if (bit_idx != `BUS_MASTER_UNIT_ACK_BIT)
                begin
                  shift <= {shift[6:0], sda_f};
                  if (!sda_low && !sda_f && !(op.rx && !is_addr))
                  begin
                    state <= bus_master_unit_pkg::ST_IDLE;
                    mode <= bus_master_unit_pkg::MD_IDLE;
                    scl_low <= 1'b0;
                    sda_low <= 1'b0;
                    flags <= 4'b1001;
                    DONE_IRQ <= 1'b1;
                  end
                end
                else
                begin
                  bit_idx <= 4'h0;
                  if (is_addr && op.hs)
                  begin
                    // master code is never acknowledged
                    state <= bus_master_unit_pkg::ST_IDLE;
                    mode <= bus_master_unit_pkg::MD_TX;
                    HS_MODE <= 1'b1;
                    DONE_IRQ <= 1'b1;
                  end
                  else if (is_addr && sda_f)
                  begin
                    // bus kept so software can follow with a stop
                    state <= bus_master_unit_pkg::ST_IDLE;
                    mode <= op.rx ? bus_master_unit_pkg::MD_RX : bus_master_unit_pkg::MD_TX;
                    flags <= 4'b0011;
                    DONE_IRQ <= 1'b1;
                  end
                  else if (is_addr)
                  begin
                    is_addr <= 1'b0;
                    shift <= op.rx ? 8'hff : tx_byte;
                  end
                  else
                  begin
                    if (op.rx)
                      rx_byte <= shift;
                    if (!op.rx && sda_f)
                      flags <= 4'b0101;
                    if (op.stop && !(!op.rx && sda_f))
                      state <= bus_master_unit_pkg::ST_STOP;
                    else
                    begin
                      state <= bus_master_unit_pkg::ST_IDLE;
                      mode <= op.rx ? bus_master_unit_pkg::MD_RX : bus_master_unit_pkg::MD_TX;
                      DONE_IRQ <= 1'b1;
                    end
                  end
                end
              end
            endcase
          end
        end
        bus_master_unit_pkg::ST_STOP:
        begin
          if (tick)
          begin
            qph <= qph + 2'h1;
            case (qph)
              2'h0:
              begin
                scl_low <= 1'b1;
                sda_low <= 1'b1;
              end
              2'h1: scl_low <= 1'b0;
              2'h2: sda_low <= 1'b0;
              default:
              begin
                state <= bus_master_unit_pkg::ST_IDLE;
                mode <= bus_master_unit_pkg::MD_IDLE;
                HS_MODE <= 1'b0;
                DONE_IRQ <= 1'b1;
              end
            endcase
          end
        end
        default: state <= bus_master_unit_pkg::ST_IDLE;
      endcase
    end
  end
  // error flag is the or of the three causes, set with them above
endmodule
`default_nettype wire

// file: verification/bus_master_unit_master_chk.sv
`include "bus_master_unit_cfg.svh"
`default_nettype none
module bus_master_unit_master_chk #(
  parameter int FILT_CYC = 3
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  input wire logic SCL_OUT,
  input wire logic SCL_OE,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic DONE_IRQ,
  input wire logic HS_MODE
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);
  logic mapped;
  assign mapped = PADDR[9:4] == 6'h3d;
  // ----
  // sequences
  // ----
  sequence s_srst_wr;
    PSEL && PENABLE && PWRITE && PADDR[9:2] == `BUS_MASTER_UNIT_IDX_CTRL && PWDATA[`BUS_MASTER_UNIT_C_SRST];
  endsequence
  sequence s_free;
    !SCL_OE && !SDA_OE && !HS_MODE;
  endsequence
  // ----
  // properties
  // ----
  a_soft_clear: assert property (s_srst_wr |-> ##[2:3] s_free)
    else $error("soft reset left lines held");
  a_open_drain: assert property (!SCL_OUT && !SDA_OUT)
    else $error("line driven high");
  a_rd_upper: assert property (PRDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_bad_addr: assert property (PSEL && !PENABLE && !mapped |=> PSLVERR)
    else $error("unmapped access not flagged");
  a_good_addr: assert property (PSEL && !PENABLE && mapped |=> !PSLVERR)
    else $error("mapped access flagged");
  a_rd_hold: assert property (PSEL && PENABLE |=> $stable(PRDATA))
    else $error("read data moved after access");
  a_irq_pulse: assert property (DONE_IRQ |=> !DONE_IRQ)
    else $error("completion pulse too long");
  a_scl_high: assert property ($fell(SCL_OE) |-> !SCL_OE [*4])
    else $error("clock high phase too short");
  a_rst_quiet: assert property ($fell(SRST) |-> s_free and !DONE_IRQ)
    else $error("outputs active after reset");
endmodule
bind bus_master_unit_master bus_master_unit_master_chk #(.FILT_CYC(FILT_CYC)) u_chk (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .DONE_IRQ(DONE_IRQ), .HS_MODE(HS_MODE));
`default_nettype wire

// file: verification/bus_master_unit_slave_model.sv
`default_nettype none
module bus_master_unit_slave_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack_data,
  input wire logic stretch,
  input wire logic [7:0] tx,
  output logic scl_oe,
  output logic sda_oe,
  output logic mack,
  output logic [31:0] log_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic on, adr, hit, rd;
  logic [3:0] cnt;
  logic [7:0] sh;
  initial
  begin
    {on, adr, hit, rd, scl_oe, sda_oe, mack} = '0;
    {cnt, sh, log_q} = '0;
  end
  // ----
  // framing, seen only while the clock is high
  // ----
  always @(negedge sda)
    if (scl)
    begin
      on = 1'b1;
      adr = 1'b1;
      cnt = 4'h0;
    end
  always @(posedge sda)
    if (scl)
    begin
      on = 1'b0;
      rd = 1'b0;
    end
  // ----
  // bits: sampled on the rise, changed on the fall
  // ----
  always @(posedge scl)
    if (on)
    begin
      if (cnt < 4'h8)
        sh = {sh[6:0], sda};
      else if (rd)
      begin
        mack = sda;
        rd = !sda; // a nack from the master ends our sending, else stop would be blocked
      end
      cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
    end
  always @(negedge scl)
    if (on)
    begin
      if (cnt == 4'h8 && adr)
      begin
        hit = sh[7:1] == ADDR;
        rd = hit & sh[0];
        adr = 1'b0;
        log_q = {log_q[23:0], sh};
        sda_oe = hit;
      end
      else if (cnt == 4'h8 && !rd)
      begin
        log_q = {log_q[23:0], sh};
        sda_oe = hit & !nack_data;
      end
      else
        sda_oe = rd && cnt < 4'h8 && !tx[3'd7 - cnt[2:0]];
      if (stretch)
      begin
        scl_oe = 1'b1;
        #400 scl_oe = 1'b0;
      end
    end
endmodule
`default_nettype wire

// file: verification/bus_master_unit_master_tb.sv
`include "bus_master_unit_cfg.svh"
`default_nettype none
module bus_master_unit_master_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] SA = {`BUS_MASTER_UNIT_IDX_ADDR, 2'b00};
  localparam logic [9:0] CR = {`BUS_MASTER_UNIT_IDX_CTRL, 2'b00};
  localparam logic [9:0] BF = {`BUS_MASTER_UNIT_IDX_BUF, 2'b00};
  localparam logic [9:0] TP = {`BUS_MASTER_UNIT_IDX_TP, 2'b00};
  logic clk_sys, srst, psel, penable, pwrite, pready, pslverr, perr;
  logic scl_oe, sda_oe, done_irq, hs_mode, s_scl, s_sda, mack, nack_d, strch, rival;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, r, slog;
  logic [7:0] s_tx;
  wire scl = !(scl_oe | s_scl);
  wire sda = !(sda_oe | s_sda | rival);
  int bad_count, checked;
  bus_master_unit_master dut (
    .CLK_SYS(clk_sys), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SCL_IN(scl), .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
    .DONE_IRQ(done_irq), .HS_MODE(hs_mode));
  bus_master_unit_slave_model slv (
    .scl(scl), .sda(sda), .nack_data(nack_d), .stretch(strch), .tx(s_tx),
    .scl_oe(s_scl), .sda_oe(s_sda), .mack(mack), .log_q(slog));
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ----
  // helpers
  // ----
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input string n, input logic [9:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(n, {24'h0, e}, r);
  endtask
  task automatic wait_irq;
    int i;
    i = 0;
    while (done_irq !== 1'b1 && i < 5000)
    begin
      @(posedge clk_sys);
      i++;
    end
    chk("done_irq", 1, {31'h0, done_irq});
    // bus-state inputs pass a synchroniser before status sees them
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    rchk("tp_rst", TP, 8'h01);
    rchk("sa_rst", SA, 8'h00);
    rchk("buf_rst", BF, 8'h00);
    rchk("status_rst", CR, 8'h20);
    wr(TP, 8'h05);
    wr(SA, 8'ha5);
    rchk("tp_rw", TP, 8'h05);
    rchk("sa_rw", SA, 8'ha5);
    apb(1'b0, 10'h3e0, 8'h00);
    chk("unmapped_err", 1, {31'h0, perr});
    wr(CR, 8'h80);
    rchk("tp_srst", TP, 8'h01);
    rchk("sa_srst", SA, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_send;
    int t0;
    int dt;
    wr(TP, 8'h02);
    wr(SA, 8'ha0);
    wr(BF, 8'h11);
    wr(CR, 8'h03);
    @(posedge scl);
    t0 = int'($time);
    @(posedge scl);
    dt = int'($time) - t0;
    // a few cycles of slack: the high phase is timed from the synchronised line
    chk("scl_period", 1, (dt >= 480 && dt <= 580) ? 1 : 0);
    wait_irq();
    rchk("tx_status", CR, 8'h40);
    wr(BF, 8'h22);
    strch = 1'b1;
    wr(CR, 8'h01);
    wait_irq();
    strch = 1'b0;
    wr(BF, 8'h33);
    wr(CR, 8'h05);
    wait_irq();
    rchk("stop_status", CR, 8'h20);
    chk("bytes_seen", 32'ha0112233, slog);
    $display("t_send done");
  endtask
  task automatic t_recv;
    s_tx = 8'h3c;
    wr(SA, 8'ha1);
    wr(CR, 8'h0b);
    wait_irq();
    chk("ack_sent", 0, {31'h0, mack});
    rchk("rx_byte", BF, 8'h3c);
    wr(CR, 8'h0f);
    repeat (100) @(posedge clk_sys);
    rchk("rx_nop", CR, 8'h40);
    s_tx = 8'h5a;
    wr(CR, 8'h05);
    wait_irq();
    chk("nack_sent", 1, {31'h0, mack});
    rchk("rx_last", BF, 8'h5a);
    rchk("rx_status", CR, 8'h20);
    $display("t_recv done");
  endtask
  task automatic t_nack;
    wr(SA, 8'ha1);
    wr(CR, 8'h0f);
    repeat (100) @(posedge clk_sys);
    rchk("idle_illegal", CR, 8'h20);
    wr(SA, 8'hb0);
    wr(CR, 8'h03);
    wait_irq();
    rchk("addr_nack", CR, 8'h46);
    wr(CR, 8'h04);
    wait_irq();
    rchk("stop_after", CR, 8'h20);
    nack_d = 1'b1;
    wr(SA, 8'ha0);
    wr(CR, 8'h07);
    wait_irq();
    rchk("data_nack", CR, 8'h4a);
    nack_d = 1'b0;
    wr(CR, 8'h04);
    wait_irq();
    rchk("nack_clear", CR, 8'h20);
    $display("t_nack done");
  endtask
  task automatic t_arb;
    rival <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rchk("bus_taken", CR, 8'h60);
    wr(SA, 8'ha0);
    wr(CR, 8'h07);
    wait_irq();
    rchk("arb_lost", CR, 8'h72);
    rival <= 1'b0;
    repeat (20) @(posedge clk_sys);
    // flags of the lost operation stay until the next command is taken
    rchk("bus_freed", CR, 8'h32);
    $display("t_arb done");
  endtask
  task automatic t_hs;
    wr(SA, 8'h00);
    wr(CR, 8'h11);
    wait_irq();
    chk("hs_on", 1, {31'h0, hs_mode});
    chk("mcode", 8'h08, {24'h0, slog[7:0]});
    wr(CR, 8'h04);
    repeat (400) @(posedge clk_sys);
    chk("hs_off", 0, {31'h0, hs_mode});
    $display("t_hs done");
  endtask
  task automatic t_filt;
    logic seen;
    seen = 1'b0;
    wr(CR, 8'h40);
    @(posedge clk_sys);
    rival <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rival <= 1'b0;
    // a two-cycle dip passes the synchroniser but must not pass the filter
    repeat (12)
    begin
      @(posedge clk_sys);
      seen = seen | dut.bus_busy;
    end
    chk("filt_glitch", 0, {31'h0, seen});
    $display("t_filt done");
  endtask
  initial
  begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 45'h0};
    {perr, nack_d, strch, rival, s_tx, r} = '0;
    bad_count = 0;
    checked = 0;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs();
    t_send();
    t_recv();
    t_nack();
    t_arb();
    t_hs();
    t_filt();
    end_sim();
  end
  initial
  begin
    #1000000;
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
